// ===== tp_comp_model.sv
// comparator stand-in: slow pulse trains on the comparator line
`timescale 1ns/1ps
module tp_comp_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] pulses,
  output logic comp_out,
  output logic busy
);
  logic lvl = 1'b0;
  int left = 0;
  int ph = 0;
  assign comp_out = lvl;
  assign busy = (left != 0);
  // each level stands four clocks, under quarter rate
  always @(posedge core_clk) begin
    if (go && left == 0) begin
      left <= 2 * int'(pulses);
    end else if (left != 0) begin
      ph <= (ph == 3) ? 0 : ph + 1;
      if (ph == 3) begin
        lvl <= ~lvl;
        left <= left - 1;
      end
    end
  end
endmodule : tp_comp_model

// ===== tp_db_if.sv
// carrier between the timer core and the deadband stage
`timescale 1ns/1ps
interface tp_db_if;
  logic lvl;
  logic dual;
  tp_pkg::tp_dband_t delay;
  logic pos;
  logic neg;
  modport src (output lvl, output dual, output delay, input pos, input neg);
  modport db (input lvl, input dual, input delay, output pos, output neg);
endinterface : tp_db_if

// ===== tp_deadband.sv
// deadband stage: delays low-to-high edges of both pwm pins
`timescale 1ns/1ps
module tp_deadband (
  input wire logic core_clk,
  input wire logic resetn,
  tp_db_if.db bus
);
  tp_pkg::tp_dband_t cnt_p_ff;
  tp_pkg::tp_dband_t cnt_n_ff;
  logic pos_ff;
  logic neg_ff;

  // ========================================================
  // true output: drops at once, rises after delay cycles
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pos_ff <= 1'b0;
      cnt_p_ff <= 8'h00;
    end else if (!bus.lvl) begin
      pos_ff <= 1'b0;
      cnt_p_ff <= 8'h00;
    end else if (!pos_ff) begin
      if (cnt_p_ff >= bus.delay) begin
        pos_ff <= 1'b1;
      end else begin
        cnt_p_ff <= cnt_p_ff + 8'h01;
      end
    end
  end

  // complement output, only live in dual mode
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      neg_ff <= 1'b0;
      cnt_n_ff <= 8'h00;
    end else if (!bus.dual || bus.lvl) begin
      neg_ff <= 1'b0;
      cnt_n_ff <= 8'h00;
    end else if (!neg_ff) begin
      if (cnt_n_ff >= bus.delay) begin
        neg_ff <= 1'b1;
      end else begin
        cnt_n_ff <= cnt_n_ff + 8'h01;
      end
    end
  end

  assign bus.pos = pos_ff;
  assign bus.neg = neg_ff;
endmodule : tp_deadband

// ===== tp_params.svh
// constants of the timer pwm block: offsets, fields, reset values
`ifndef TP_PARAMS_SVH
`define TP_PARAMS_SVH
// ==========================================================
// register byte offsets
`define TP_OFF_CTRL 8'h00
`define TP_OFF_CTRL2 8'h04
`define TP_OFF_COUNT 8'h08
`define TP_OFF_MATCH 8'h0C
`define TP_OFF_RELOAD 8'h10
`define TP_OFF_DBAND 8'h14
`define TP_OFF_STAT 8'h18
// ==========================================================
// field positions
`define TP_CTRL_EN 0
`define TP_CTRL_MODE 1
`define TP_CTRL_POL 2
`define TP_CTRL_OUTEN 3
`define TP_CTRL_PS_HI 6
`define TP_CTRL_PS_LO 4
`define TP_CTRL2_MHI 0
// ==========================================================
// reset and restart values, deadband limit, response codes
`define TP_CTRL_RST 8'h00
`define TP_CNT_RST 16'h0001
`define TP_CNT_RESTART 16'h0001
`define TP_RELOAD_RST 16'h0000
`define TP_MATCH_RST 16'h0000
`define TP_DB_MAX 8'h80
`define TP_RESP_OKAY 2'h0
`define TP_RESP_SLVERR 2'h2
`endif

// ===== tp_pkg.sv
// types shared by the timer pwm block
package tp_pkg;
  // ========================================================
  // counting mode carried in the mode field
  typedef enum logic {
    TP_MODE_CMPCNT = 1'b0,
    TP_MODE_PWM = 1'b1
  } tp_mode_e;
  typedef logic [7:0] tp_dband_t;
endpackage : tp_pkg

// ===== tp_timer_monitor.sv
// checker of bus handshakes and pwm pin relations
`timescale 1ns/1ps
module tp_timer_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tout,
  input wire logic tcomp_out,
  input wire logic tcomp_oe
);
  // ==========================================
  // clocking and handshake steps
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================
  // register bus answers
  // write lands one edge after the handshake, answer shows the edge after
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_busy: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_write_reopen: assert property (s_axi_bvalid && s_axi_bready
    |=> s_axi_awready && s_axi_wready)
    else $error("write path not reopened");
  // ==========================================
  // pin pair relations
  a_dual_no_overlap: assert property (tcomp_oe
    |-> !(tout && tcomp_out))
    else $error("both pwm pins high");
  a_comp_quiet: assert property (!tcomp_oe [*2] |-> !tcomp_out)
    else $error("complement active outside dual");
endmodule : tp_timer_monitor
bind tp_timer_top tp_timer_monitor mon (.*);

// ===== tp_timer_top.sv
// timer with comparator counting and single or dual pwm output
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tp_params.svh"
module tp_timer_top #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comp_out,
  output logic tout,
  output logic tout_oe,
  output logic tcomp_out,
  output logic tcomp_oe,
  output logic timer_irq
);

  // ========================================================
  // byte lane merge helpers
  function automatic logic [7:0] tp_merge8(
    input logic [7:0] old,
    input logic [31:0] d,
    input logic [3:0] s
  );
    tp_merge8 = s[0] ? d[7:0] : old;
  endfunction : tp_merge8

  function automatic logic [15:0] tp_merge16(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0] s
  );
    tp_merge16 = old;
    if (s[0]) tp_merge16[7:0] = d[7:0];
    if (s[1]) tp_merge16[15:8] = d[15:8];
  endfunction : tp_merge16

  // word offset with low address bits dropped
  function automatic logic [7:0] tp_word(input logic [ADDR_W-1:0] a);
    tp_word = {a[7:2], 2'b00};
  endfunction : tp_word

  // ========================================================
  // bus state
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [7:0] awoff_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_en;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;

  // timer state
  logic [7:0] ctrl_ff;
  logic [7:0] ctrl2_ff;
  logic [15:0] count_ff;
  logic [15:0] match_ff;
  logic [15:0] reload_ff;
  tp_pkg::tp_dband_t dband_ff;
  logic [6:0] presc_ff;
  logic comp_q_ff;
  logic level_ff;
  logic irq_ff;
  logic tout_oe_ff;
  logic tcomp_oe_ff;

  logic en;
  tp_pkg::tp_mode_e mode;
  logic pol;
  logic dual;
  logic [2:0] ps;
  logic [6:0] presc_lim;
  logic presc_hit;
  logic edge_hit;
  logic tick;
  logic reload_hit;
  logic match_hit;
  logic [7:0] db_new;

  tp_db_if db_bus ();

  // ========================================================
  // write channel: address and data taken in either order
  assign wr_en = !awready_ff && !wready_ff && !bvalid_ff;

  always_comb begin
    case (awoff_ff)
      `TP_OFF_CTRL, `TP_OFF_CTRL2, `TP_OFF_COUNT, `TP_OFF_MATCH,
      `TP_OFF_RELOAD, `TP_OFF_DBAND, `TP_OFF_STAT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `TP_RESP_OKAY;
      awoff_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awoff_ff <= tp_word(s_axi_awaddr);
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end
      if (wr_en) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `TP_RESP_OKAY : `TP_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ========================================================
  // read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (tp_word(s_axi_araddr))
      `TP_OFF_CTRL: rd_val[7:0] = ctrl_ff;
      `TP_OFF_CTRL2: rd_val[7:0] = ctrl2_ff;
      `TP_OFF_COUNT: rd_val[15:0] = count_ff;
      `TP_OFF_MATCH: rd_val[15:0] = match_ff;
      `TP_OFF_RELOAD: rd_val[15:0] = reload_ff;
      `TP_OFF_DBAND: rd_val[7:0] = dband_ff;
      `TP_OFF_STAT: rd_val[3:0] = {comp_q_ff, tcomp_out, tout, level_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: answer one cycle after the address
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= `TP_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_hit ? `TP_RESP_OKAY : `TP_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ========================================================
  // control registers
  assign db_new = tp_merge8(dband_ff, wdata_ff, wstrb_ff);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_ff <= `TP_CTRL_RST;
      ctrl2_ff <= `TP_CTRL_RST;
      match_ff <= `TP_MATCH_RST;
      reload_ff <= `TP_RELOAD_RST;
      dband_ff <= 8'h00;
    end else if (wr_en) begin
      case (awoff_ff)
        `TP_OFF_CTRL: ctrl_ff <= tp_merge8(ctrl_ff, wdata_ff, wstrb_ff);
        `TP_OFF_CTRL2:
          ctrl2_ff <= tp_merge8(ctrl2_ff, wdata_ff, wstrb_ff);
        `TP_OFF_MATCH:
          match_ff <= tp_merge16(match_ff, wdata_ff, wstrb_ff);
        `TP_OFF_RELOAD:
          reload_ff <= tp_merge16(reload_ff, wdata_ff, wstrb_ff);
        // deadband saturates at the largest legal delay
        `TP_OFF_DBAND: begin
          dband_ff <= (db_new > `TP_DB_MAX) ? `TP_DB_MAX : db_new;
        end
        default: ;
      endcase
    end
  end

  // ========================================================
  // mode decode and tick source
  assign en = ctrl_ff[`TP_CTRL_EN];
  assign mode = tp_pkg::tp_mode_e'(ctrl_ff[`TP_CTRL_MODE]);
  assign pol = ctrl_ff[`TP_CTRL_POL];
  assign ps = ctrl_ff[`TP_CTRL_PS_HI:`TP_CTRL_PS_LO];
  assign dual = (mode == tp_pkg::TP_MODE_PWM) && ctrl2_ff[`TP_CTRL2_MHI];
  assign presc_lim = 7'((8'h01 << ps) - 8'h01);
  assign presc_hit = (presc_ff == presc_lim);

  // selected comparator edge, polarity high means rising
  assign edge_hit = pol ? (comp_out && !comp_q_ff)
                        : (!comp_out && comp_q_ff);

  assign tick = en && ((mode == tp_pkg::TP_MODE_PWM) ? presc_hit
                                                     : edge_hit);
  assign reload_hit = tick && (count_ff == reload_ff);
  assign match_hit = tick && (count_ff == match_ff);

  // comparator sample for edge detection
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      comp_q_ff <= 1'b0;
    end else begin
      comp_q_ff <= comp_out;
    end
  end

  // prescaler, held clear when idle or counting edges
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      presc_ff <= 7'h00;
    end else if (!en || mode != tp_pkg::TP_MODE_PWM || presc_hit) begin
      presc_ff <= 7'h00;
    end else begin
      presc_ff <= presc_ff + 7'h01;
    end
  end

  // ========================================================
  // counter: software write wins, then reload, then step
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_ff <= `TP_CNT_RST;
    end else if (wr_en && awoff_ff == `TP_OFF_COUNT) begin
      count_ff <= tp_merge16(count_ff, wdata_ff, wstrb_ff);
    end else if (reload_hit) begin
      count_ff <= `TP_CNT_RESTART;
    end else if (tick) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // ========================================================
  // output level: idles at polarity; pwm flips at match and returns to polarity at reload, counting flips at reload
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      level_ff <= 1'b0;
    end else if (!en) begin
      level_ff <= pol;
    end else if (reload_hit) begin
      if (mode == tp_pkg::TP_MODE_PWM) begin
        level_ff <= pol;
      end else begin
        level_ff <= !level_ff;
      end
    end else if (match_hit && mode == tp_pkg::TP_MODE_PWM) begin
      level_ff <= !level_ff;
    end
  end

  // interrupt request pulse at each reload
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= reload_hit;
    end
  end

  // pin enables: complement takes over the input pin
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tout_oe_ff <= 1'b0;
      tcomp_oe_ff <= 1'b0;
    end else begin
      tout_oe_ff <= ctrl_ff[`TP_CTRL_OUTEN];
      tcomp_oe_ff <= dual;
    end
  end

  // ========================================================
  // deadband stage, no delay outside dual mode
  assign db_bus.lvl = level_ff;
  assign db_bus.dual = dual;
  assign db_bus.delay = dual ? dband_ff : 8'h00;

  tp_deadband u_deadband (
    .core_clk (core_clk),
    .resetn (resetn),
    .bus (db_bus.db)
  );

  // ========================================================
  // port drive
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign tout = db_bus.pos;
  assign tcomp_out = db_bus.neg;
  assign tout_oe = tout_oe_ff;
  assign tcomp_oe = tcomp_oe_ff;
  assign timer_irq = irq_ff;

endmodule : tp_timer_top

// ===== tp_timer_top_bench.sv
// bench: bus tasks, pin counters and mode scenarios
`timescale 1ns/1ps
`include "tp_params.svh"
module tp_timer_top_bench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic go = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tout, tout_oe, tcomp_out, tcomp_oe, timer_irq;
  logic comp_out, cm_busy, last_tout;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [31:0] seed = 32'h59;
  logic [1:0] b_q[$];
  logic [33:0] r_q[$];
  logic [33:0] d_i, d_h, d_o, d_t;
  int bad_count = 0;
  int cmp_count = 0;
  int n_irq = 0, n_hi = 0, n_co = 0, n_tg = 0;
  int s_i, s_h, s_o, s_t;

  tp_timer_top uut (.*);
  tp_comp_model cm (.core_clk(core_clk), .go(go), .pulses(pulses),
    .comp_out(comp_out), .busy(cm_busy));

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    b_q.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awprot <= 3'(rnd());
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // idle edge: a following call never re-raises ready in this step
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    r_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arprot <= 3'(rnd());
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    // idle edge: a following call never re-raises ready in this step
    @(posedge core_clk);
  endtask : rd

  // setup with timer stopped, enable written last
  task automatic cfg(input logic [7:0] c, input logic [7:0] c2,
    input logic [15:0] cnt, input logic [15:0] m,
    input logic [15:0] rl, input logic [7:0] db);
    wr(`TP_OFF_CTRL, {24'h0, c});
    wr(`TP_OFF_CTRL2, {24'h0, c2});
    wr(`TP_OFF_COUNT, {16'h0, cnt});
    wr(`TP_OFF_MATCH, {16'h0, m});
    wr(`TP_OFF_RELOAD, {16'h0, rl});
    wr(`TP_OFF_DBAND, {24'h0, db});
    wr(`TP_OFF_CTRL, {24'h0, c | 8'h01});
  endtask : cfg

  task automatic pulse(input logic [7:0] n);
    pulses <= n;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    while (cm_busy) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
  endtask : pulse

  task automatic snap();
    #1;
    s_i = n_irq; s_h = n_hi; s_o = n_co; s_t = n_tg;
    @(posedge core_clk);
  endtask : snap

  task automatic grab();
    #1;
    d_i = 34'(n_irq - s_i);
    d_h = 34'(n_hi - s_h);
    d_o = 34'(n_co - s_o);
    d_t = 34'(n_tg - s_t);
    @(posedge core_clk);
  endtask : grab

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // bus answers against oldest note, pin activity counters
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk({32'h0, s_axi_bresp}, {32'h0, b_q.pop_front()});
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, r_q.pop_front());
    n_irq <= n_irq + int'(timer_irq);
    n_hi <= n_hi + int'(tout);
    n_co <= n_co + int'(tcomp_out);
    n_tg <= n_tg + int'(tout ^ last_tout);
    last_tout <= tout;
  end

  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    final_report();
  end

  // ==========================================
  // scenarios
  initial begin
    int per, db;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(`TP_OFF_CTRL, 32'h0);
    rd(`TP_OFF_COUNT, 32'h1);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h1C, 32'h5, 2'h2);
    wr(`TP_OFF_DBAND, 32'hC8);
    rd(`TP_OFF_DBAND, 32'h80);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      per = 4 << (k >> 1);
      cfg(8'(8'h0A | ((k & 1) << 2) | ((k >> 1) << 4)), 8'h00,
        16'h0003, 16'h0001, 16'h0004, 8'h00);
      repeat (2 * per) @(posedge core_clk);
      snap();
      repeat (5 * per - 1) @(posedge core_clk);
      grab();
      chk(d_i, 34'h5);
      chk(d_h, 34'((k & 1 ? 5 : 15) << (k >> 1)));
      chk({33'h0, tcomp_oe}, 34'h0);
    end
    $display("test single pwm done");
    for (int k = 0; k < 2; k++) begin
      cfg(8'(8'h78 | (k << 2)), 8'h00, 16'h0002, 16'h0000,
        16'h0003, 8'h00);
      repeat (3) @(posedge core_clk);
      chk({33'h0, tout}, 34'(k));
      chk({33'h0, tout_oe}, 34'h1);
      snap();
      pulse(8'h0C);
      grab();
      chk(d_i, 34'h4);
      chk(d_t, 34'h4);
      rd(`TP_OFF_COUNT, 32'h2);
    end
    cfg(8'h0C, 8'h00, 16'hFFFE, 16'h0000, 16'h0000, 8'h00);
    snap();
    pulse(8'h03);
    grab();
    chk(d_i, 34'h1);
    rd(`TP_OFF_COUNT, 32'h1);
    $display("test comparator counting done");
    for (int k = 0; k < 2; k++) begin
      db = k ? 0 : 1 + int'(rnd() % 5);
      cfg(8'h0E, 8'h01, 16'h0001, 16'h0006, 16'h0010, 8'(db));
      repeat (32) @(posedge core_clk);
      snap();
      repeat (47) @(posedge core_clk);
      grab();
      chk(d_i, 34'h3);
      chk(d_h, 34'(18 - 3 * db));
      chk(d_o, 34'(30 - 3 * db));
      chk({33'h0, tcomp_oe}, 34'h1);
    end
    $display("test dual pwm done");
    final_report();
  end
endmodule : tp_timer_top_bench
